//--- qdsw_host_model.sv
// host side model that drives the serial write port pins
`timescale 1ns/1ps
module qdsw_host_model
(
  // clock
  input wire logic i_clk,
  // serial link pins
  output logic o_frame_sel_b,
  output logic o_sclk,
  output logic o_din
);
  initial
  begin
    o_frame_sel_b = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_clk);
  endtask : hold

  // ------------------------------------------------------------
  // frame transfer
  // ------------------------------------------------------------
  task automatic send(input logic [23:0] word, input int nbits,
                      input bit new_frame, input bit raise_end);
    // select high 80 ns, then its fall opens the frame
    if (new_frame)
    begin
      o_frame_sel_b <= 1'b1;
      hold(4);
      o_frame_sel_b <= 1'b0;
      hold(4);
    end
    // msb first on a 160 ns shift clock, idle high
    for (int i = 23; i > 23 - nbits; i--)
    begin
      o_din <= word[i];
      hold(4);
      o_sclk <= 1'b0;
      hold(4);
      o_sclk <= 1'b1;
    end
    // data no longer held: show the inverse rather than a stale bit
    o_din <= ~word[24 - nbits];
    // select either rises or stays low after the last edge
    if (raise_end)
      o_frame_sel_b <= 1'b1;
    hold(4);
  endtask : send
endmodule : qdsw_host_model

//--- qdsw_pkg.sv
// constants, state encoding and state record of the serial write port
// Function
// - each falling shift clock edge in a frame shifts one data bit in
// - the 24th falling edge completes the frame and runs the command
// - select may stay low or rise after the 24th edge, same result
// - code is plain unsigned binary, full range of the code width
// - converter register code drives the tap and holds until next update
// - select rising early clears the shift register, nothing executes
// - frame: two spare bits, command, channel address, then the code
// - command 010 writes the addressed input register (all four for address 111) then loads all converters
package qdsw_pkg;

  // --------------------------------------------------------------
  // frame layout
  // --------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [4:0] BIT_STEP = 5'h1;
  localparam int CMD_MSB = 21;
  localparam int CMD_LSB = 19;
  localparam int ADDR_MSB = 18;
  localparam int ADDR_LSB = 16;
  localparam int CODE_W = 16;
  localparam int CH_NUM = 4;
  localparam int PD_MSB = 5;
  localparam int PD_LSB = 4;
  localparam int RST_FULL_BIT = 0;

  // --------------------------------------------------------------
  // commands and addresses
  // --------------------------------------------------------------
  localparam logic [2:0] CMD_WR_IN = 3'h0;
  localparam logic [2:0] CMD_UPD_N = 3'h1;
  localparam logic [2:0] CMD_WR_UPD_ALL = 3'h2;
  localparam logic [2:0] CMD_WR_UPD_N = 3'h3;
  localparam logic [2:0] CMD_PWR = 3'h4;
  localparam logic [2:0] CMD_SW_RST = 3'h5;
  localparam logic [2:0] CMD_LD_MASK = 3'h6;
  localparam logic [2:0] ADDR_ALL = 3'h7;

  // --------------------------------------------------------------
  // reset values and timing
  // --------------------------------------------------------------
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [23:0] SHREG_ZERO = 24'h00_0000;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [3:0] MASK_ZERO = 4'h0;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEL_HIGH_MIN_NS = 15;
  localparam int SEL_HIGH_RAW =
    (SEL_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_HIGH_MIN_CYC = (SEL_HIGH_RAW < 1) ? 1 : SEL_HIGH_RAW;
  localparam int SCLK_MAX_MHZ = 50;

  typedef enum logic [3:0] {
    ST_WAIT_HIGH = 4'h1,
    ST_ARMED = 4'h2,
    ST_SHIFT = 4'h4,
    ST_DONE = 4'h8
  } qdsw_state_t;

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic din_s1;
    logic din_s2;
    qdsw_state_t st;
    logic [4:0] bitcnt;
    logic [23:0] shreg;
    logic [3:0][15:0] inreg;
    logic [3:0][15:0] dacreg;
    logic [3:0][1:0] pd_mode;
    logic [3:0] simultaneous_load_mask;
    logic exec;
    logic [2:0] last_cmd;
    logic [2:0] last_addr;
    logic [15:0] last_code;
    logic seen_exec;
  } qdsw_regs_t;

endpackage : qdsw_pkg

//--- qdsw_serial_port.sv
// serial write port of a quad converter: sampling, framing, execution
`timescale 1ns/1ps
module qdsw_serial_port
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // serial link pins
  input wire logic i_frame_sel_b,
  input wire logic i_sclk,
  input wire logic i_din,
  // converter side
  output logic [3:0][15:0] o_dac_code,
  output logic [3:0][1:0] o_pd_mode,
  output logic [3:0] o_simultaneous_load_mask,
  output logic o_exec
);

  // --------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_b_ff;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_s1_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_b_ff <= rst_s1_ff;
    end
  end

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  qdsw_pkg::qdsw_regs_t q_ff;
  qdsw_pkg::qdsw_regs_t nxt_q;
  logic sclk_fall;

  // pins are sampled, so the link clock must stay well below i_clk / 4
  assign sclk_fall = q_ff.sclk_d & ~q_ff.sclk_s2;

  always_comb
  begin
    logic [23:0] frame;
    logic [2:0] cmd;
    logic [2:0] addr;
    logic [15:0] code;
    logic hit;
    frame = {q_ff.shreg[22:0], q_ff.din_s2};
    cmd = frame[qdsw_pkg::CMD_MSB:qdsw_pkg::CMD_LSB];
    addr = frame[qdsw_pkg::ADDR_MSB:qdsw_pkg::ADDR_LSB];
    code = frame[qdsw_pkg::CODE_W-1:0];
    hit = 1'b0;
    nxt_q = q_ff;
    nxt_q.exec = 1'b0;
    nxt_q.sel_s1 = i_frame_sel_b;
    nxt_q.sel_s2 = q_ff.sel_s1;
    nxt_q.sclk_s1 = i_sclk;
    nxt_q.sclk_s2 = q_ff.sclk_s1;
    nxt_q.sclk_d = q_ff.sclk_s2;
    nxt_q.din_s1 = i_din;
    nxt_q.din_s2 = q_ff.din_s1;
    case (q_ff.st)
      qdsw_pkg::ST_WAIT_HIGH:
      begin
        if (q_ff.sel_s2)
          nxt_q.st = qdsw_pkg::ST_ARMED;
      end
      qdsw_pkg::ST_ARMED:
      begin
        nxt_q.shreg = qdsw_pkg::SHREG_ZERO;
        nxt_q.bitcnt = 5'h0;
        if (!q_ff.sel_s2)
          nxt_q.st = qdsw_pkg::ST_SHIFT;
      end
      qdsw_pkg::ST_SHIFT:
      begin
        if (q_ff.sel_s2)
        begin
          nxt_q.shreg = qdsw_pkg::SHREG_ZERO;
          nxt_q.st = qdsw_pkg::ST_ARMED;
        end
        else if (sclk_fall)
        begin
          nxt_q.shreg = frame;
          nxt_q.bitcnt = q_ff.bitcnt + qdsw_pkg::BIT_STEP;
          if (q_ff.bitcnt == qdsw_pkg::LAST_BIT)
          begin
            nxt_q.exec = 1'b1;
            nxt_q.seen_exec = 1'b1;
            nxt_q.last_cmd = cmd;
            nxt_q.last_addr = addr;
            nxt_q.last_code = code;
            nxt_q.st = qdsw_pkg::ST_DONE;
            for (int ch = 0; ch < qdsw_pkg::CH_NUM; ch++)
            begin
              hit = (addr == 3'(ch)) || (addr == qdsw_pkg::ADDR_ALL);
              case (cmd)
                qdsw_pkg::CMD_WR_IN:
                begin
                  if (hit)
                    nxt_q.inreg[ch] = code;
                  if (hit && q_ff.simultaneous_load_mask[ch])
                    nxt_q.dacreg[ch] = code;
                end
                qdsw_pkg::CMD_UPD_N:
                begin
                  if (hit)
                    nxt_q.dacreg[ch] = q_ff.inreg[ch];
                end
                qdsw_pkg::CMD_WR_UPD_ALL:
                begin
                  if (hit)
                    nxt_q.inreg[ch] = code;
                  nxt_q.dacreg[ch] = hit ? code : q_ff.inreg[ch];
                end
                qdsw_pkg::CMD_WR_UPD_N:
                begin
                  if (hit)
                  begin
                    nxt_q.inreg[ch] = code;
                    nxt_q.dacreg[ch] = code;
                  end
                end
                qdsw_pkg::CMD_PWR:
                begin
                  if (frame[ch])
                    nxt_q.pd_mode[ch] =
                      frame[qdsw_pkg::PD_MSB:qdsw_pkg::PD_LSB];
                end
                qdsw_pkg::CMD_SW_RST:
                begin
                  nxt_q.inreg[ch] = qdsw_pkg::CODE_ZERO;
                  nxt_q.dacreg[ch] = qdsw_pkg::CODE_ZERO;
                  if (frame[qdsw_pkg::RST_FULL_BIT])
                  begin
                    nxt_q.pd_mode[ch] = qdsw_pkg::PD_NORMAL;
                    nxt_q.simultaneous_load_mask[ch] = 1'b0;
                  end
                end
                qdsw_pkg::CMD_LD_MASK:
                begin
                  nxt_q.simultaneous_load_mask[ch] = frame[ch];
                end
                default:
                begin
                  hit = 1'b0;
                end
              endcase
            end
          end
        end
      end
      qdsw_pkg::ST_DONE:
      begin
        if (q_ff.sel_s2)
          nxt_q.st = qdsw_pkg::ST_ARMED;
      end
      default:
      begin
        nxt_q.st = qdsw_pkg::ST_WAIT_HIGH;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_b_ff)
  begin
    if (!rst_b_ff)
    begin
      q_ff <= '0;
      q_ff.sel_s1 <= 1'b1;
      q_ff.sel_s2 <= 1'b1;
      q_ff.st <= qdsw_pkg::ST_WAIT_HIGH;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign o_dac_code = q_ff.dacreg;
  assign o_pd_mode = q_ff.pd_mode;
  assign o_simultaneous_load_mask = q_ff.simultaneous_load_mask;
  assign o_exec = q_ff.exec;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_b_ff);

  sequence s_shifting_fall;
    q_ff.st == qdsw_pkg::ST_SHIFT && !q_ff.sel_s2 && sclk_fall;
  endsequence

  sequence s_early_rise;
    q_ff.st == qdsw_pkg::ST_SHIFT && q_ff.sel_s2;
  endsequence

  a_shift_capture: assert property (
    s_shifting_fall |=> q_ff.shreg == {$past(q_ff.shreg[22:0]),
                                       $past(q_ff.din_s2)})
    else $error("shift register missed a bit");

  a_exec_on_last: assert property (
    q_ff.exec |-> $past(q_ff.bitcnt) == qdsw_pkg::LAST_BIT && $past(sclk_fall))
    else $error("command ran on a wrong edge");

  a_exec_then_done: assert property (
    q_ff.exec |-> q_ff.st == qdsw_pkg::ST_DONE ##1 !q_ff.exec)
    else $error("execution not followed by done state");

  a_abort_clear: assert property (
    s_early_rise |=> q_ff.shreg == 24'h00_0000 && !q_ff.exec
                     && $stable(q_ff.dacreg) && $stable(q_ff.pd_mode))
    else $error("aborted frame changed state");

  a_code_stable: assert property (
    !$stable(q_ff.dacreg) |-> q_ff.exec)
    else $error("converter code moved without a command");

  a_load_all: assert property (
    q_ff.exec && q_ff.last_cmd == 3'h2 |-> q_ff.dacreg == q_ff.inreg)
    else $error("load-all left a converter register stale");

  a_ignore_after: assert property (
    q_ff.st == qdsw_pkg::ST_DONE && !q_ff.sel_s2 |=> !q_ff.exec)
    else $error("extra clock edges acted after execution");

  a_power_zero: assert property (
    !q_ff.seen_exec |-> q_ff.dacreg == '0 && q_ff.inreg == '0)
    else $error("converter register not zero before first frame");

  a_plain_code: assert property (
    q_ff.exec && q_ff.last_cmd == 3'h3 && q_ff.last_addr < 3'h4
    |-> q_ff.dacreg[q_ff.last_addr[1:0]] == q_ff.last_code)
    else $error("written code not stored as sent");

endmodule : qdsw_serial_port

//--- tb_quad_dac_serial_write_port.sv
// self-checking bench of the serial write port
`timescale 1ns/1ps
module tb_quad_dac_serial_write_port;
  logic i_clk;
  logic i_rst_b;
  logic frame_sel_b;
  logic sclk;
  logic din;
  logic [3:0][15:0] o_dac_code;
  logic [3:0][1:0] o_pd_mode;
  logic [3:0] o_simultaneous_load_mask;
  logic o_exec;
  int fail_count;
  int comparisons;
  int exec_seen = 0;
  int exp_exec;
  logic [3:0][15:0] exp_code;

  qdsw_serial_port u_qdsw_serial_port (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_frame_sel_b(frame_sel_b), .i_sclk(sclk), .i_din(din),
    .o_dac_code(o_dac_code), .o_pd_mode(o_pd_mode),
    .o_simultaneous_load_mask(o_simultaneous_load_mask), .o_exec(o_exec));
  qdsw_host_model u_qdsw_host_model (.i_clk(i_clk),
    .o_frame_sel_b(frame_sel_b), .o_sclk(sclk), .o_din(din));

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
    if (o_exec === 1'b1)
      exec_seen <= exec_seen + 1;

  // ------------------------------------------------------------
  // compare tasks and verdict
  // ------------------------------------------------------------
  task automatic chk_codes(input logic [3:0][15:0] exp);
    comparisons++;
    if (o_dac_code !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: codes %h", $time, o_dac_code);
    end
  endtask : chk_codes

  task automatic chk_exec(input int exp);
    comparisons++;
    if (exec_seen != exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %0d executions", $time, exec_seen);
    end
  endtask : chk_exec

  task automatic chk_mode(input logic [3:0][1:0] pd, input logic [3:0] m);
    comparisons++;
    if (o_pd_mode !== pd || o_simultaneous_load_mask !== m)
    begin
      fail_count++;
      $display("unexpected at %0t: mode %h mask %h", $time, o_pd_mode,
               o_simultaneous_load_mask);
    end
  endtask : chk_mode

  task automatic wrap_up;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic frame(input logic [23:0] w, input int n, input bit nf,
                       input bit re);
    u_qdsw_host_model.send(w, n, nf, re);
    repeat (10) @(posedge i_clk);
  endtask : frame

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_write_load;
    frame({2'b00, qdsw_pkg::CMD_WR_IN, 3'h0, 16'h1234}, 24, 1, 1);
    exp_exec++;
    chk_codes(exp_code);
    frame({2'b11, qdsw_pkg::CMD_WR_UPD_ALL, 3'h1, 16'hFFFF}, 24, 1, 1);
    exp_exec++;
    exp_code[0] = 16'h1234;
    exp_code[1] = 16'hFFFF;
    chk_codes(exp_code);
    chk_exec(exp_exec);
  endtask : t_write_load

  task automatic t_abort_ignore;
    frame({2'b00, qdsw_pkg::CMD_WR_UPD_N, 3'h0, 16'h0000}, 23, 1, 1);
    chk_exec(exp_exec);
    frame({2'b00, qdsw_pkg::CMD_WR_UPD_N, 3'h2, 16'h8000}, 24, 1, 0);
    exp_exec++;
    exp_code[2] = 16'h8000;
    chk_codes(exp_code);
    frame({2'b00, qdsw_pkg::CMD_WR_UPD_N, 3'h3, 16'h5555}, 24, 0, 1);
    chk_codes(exp_code);
    chk_exec(exp_exec);
  endtask : t_abort_ignore

  task automatic t_modes;
    frame({2'b00, qdsw_pkg::CMD_PWR, 3'h0, 10'h000, 2'h2, 4'h5}, 24, 1, 1);
    frame({2'b00, qdsw_pkg::CMD_LD_MASK, 3'h0, 12'h000, 4'hA}, 24, 1, 1);
    exp_exec += 2;
    chk_mode({2'h0, 2'h2, 2'h0, 2'h2}, 4'hA);
    frame({2'b00, qdsw_pkg::CMD_SW_RST, 3'h0, 16'h0001}, 24, 1, 1);
    exp_exec++;
    exp_code = '0;
    chk_mode('0, 4'h0);
    chk_codes('0);
    chk_exec(exp_exec);
  endtask : t_modes

  task automatic t_load_paths;
    frame({2'b00, qdsw_pkg::CMD_WR_IN, 3'h3, 16'hA5A5}, 24, 1, 1);
    chk_codes(exp_code);
    frame({2'b00, qdsw_pkg::CMD_UPD_N, 3'h3, 16'h0000}, 24, 1, 1);
    exp_code[3] = 16'hA5A5;
    chk_codes(exp_code);
    frame({2'b00, qdsw_pkg::CMD_LD_MASK, 3'h0, 12'h000, 4'h2}, 24, 1, 1);
    frame({2'b00, qdsw_pkg::CMD_WR_IN, 3'h1, 16'h0FF0}, 24, 1, 1);
    exp_code[1] = 16'h0FF0;
    chk_mode('0, 4'h2);
    chk_codes(exp_code);
    frame({2'b00, qdsw_pkg::CMD_WR_UPD_N, qdsw_pkg::ADDR_ALL, 16'h7FFF}, 24,
          1, 1);
    exp_code = {4{16'h7FFF}};
    chk_codes(exp_code);
    frame({2'b00, 3'h7, 3'h0, 16'h1111}, 24, 1, 1);
    frame({2'b00, qdsw_pkg::CMD_WR_UPD_N, 3'h5, 16'h2222}, 24, 1, 1);
    exp_exec += 7;
    chk_codes(exp_code);
    chk_exec(exp_exec);
  endtask : t_load_paths

  task automatic t_reset_mid;
    i_rst_b <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (8) @(posedge i_clk);
    exp_code = '0;
    chk_codes(exp_code);
    chk_mode('0, 4'h0);
    frame({2'b00, qdsw_pkg::CMD_WR_UPD_N, 3'h0, 16'h0001}, 24, 1, 1);
    exp_exec++;
    exp_code[0] = 16'h0001;
    chk_codes(exp_code);
    chk_exec(exp_exec);
  endtask : t_reset_mid

  initial
  begin
    fail_count = 0;
    comparisons = 0;
    exp_exec = 0;
    exp_code = '0;
    i_rst_b = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk_codes('0);
    chk_mode('0, 4'h0);
    t_write_load();
    t_abort_ignore();
    t_modes();
    t_load_paths();
    t_reset_mid();
    wrap_up();
  end

  // hang guard: sixteen frames take about 70 us
  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule : tb_quad_dac_serial_write_port
